/* thcm_pkg.sv */
// Constants, register map, diagnostic codes and state encoding shared by
// the two-hand control monitor, its checker and its testbench.
// Assumes a single 40 MHz clock and a classic Wishbone register bus.
package thcm_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    // Clock rate in kHz; keeps the product below two to the thirty-first.
    localparam int unsigned CLK_FREQ_KHZ = 40_000;
    // Synchronisation window between both hands, in milliseconds.
    localparam int unsigned SYNC_WINDOW_MS = 500;
    // Window length in clock cycles.
    localparam int unsigned SYNC_WINDOW_CYCLES = SYNC_WINDOW_MS * CLK_FREQ_KHZ;
    // Cycles after reset before the synchronised pins are trusted.
    localparam logic [1:0] SETTLE_LAST = 2'h3;

    // ----------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] DIAG_OFS = 8'h08;
    localparam int CTRL_DUAL_BIT = 0;
    localparam int CTRL_EXT_EN_BIT = 1;
    localparam logic CTRL_DUAL_RESET = 1'b1;
    localparam logic CTRL_EXT_EN_RESET = 1'b0;
    localparam int STATUS_ENABLE_BIT = 0;
    localparam int STATUS_ERROR_BIT = 1;
    localparam int STATUS_PINS_LSB = 4;

    // ----------------------------------------------------------------
    // Diagnostic codes
    // ----------------------------------------------------------------
    localparam logic [31:0] DG_NO_ENABLE = 32'h0000_0000;
    localparam logic [31:0] DG_WAIT_FIRST = 32'h0000_2001;
    localparam logic [31:0] DG_ONE_CHANNEL = 32'h0000_2005;
    localparam logic [31:0] DG_REST = 32'h0000_2016;
    localparam logic [31:0] DG_BTN1_UNDEF = 32'h0000_2017;
    localparam logic [31:0] DG_BTN2_UNDEF = 32'h0000_2018;
    localparam logic [31:0] DG_OPERATED = 32'h0000_800B;
    localparam logic [31:0] DG_ERR_LATE = 32'h0000_F006;
    localparam logic [31:0] DG_ERR_ONE_CH = 32'h0000_F00E;
    localparam logic [31:0] DG_ERR_STARTUP = 32'h0000_F018;

    // ----------------------------------------------------------------
    // Monitor states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_START,
        ST_REST,
        ST_ACTUATING,
        ST_ENABLED,
        ST_RELEASE,
        ST_ERROR
    } thcm_state_t;

endpackage

/* thcm_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static compared with the clock.
`timescale 1ns/10ps
module thcm_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Raw pins and their synchronised copy.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    // Both stages; the first is read by the second stage only.
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } thcm_sync_regs_t;

    thcm_sync_regs_t sync_reg;
    thcm_sync_regs_t sync_next;

    // Shift the pins through both stages.
    always_comb
    begin
        sync_next.stage1 = pin_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    // Register the stages; reset clears them.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign pin_sync = sync_reg.stage2;

endmodule

/* thcm_window_timer.sv */
// Window timer: counts while run is high and flags expiry after LIMIT cycles.
// Assumes run stays high for the whole window; dropping it restarts the count.
`timescale 1ns/10ps
module thcm_window_timer #(
    parameter int unsigned LIMIT = 20_000_000,
    parameter int WIDTH = $clog2(LIMIT + 1)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Run request and expiry flag.
    input wire logic run,
    output logic expired
);

    // Last count value before expiry.
    localparam logic [WIDTH-1:0] LAST = WIDTH'(LIMIT - 1);

    // Count and expiry flag.
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic expired;
    } thcm_timer_regs_t;

    thcm_timer_regs_t tmr_reg;
    thcm_timer_regs_t tmr_next;

    // Clear when idle, count while running, hold once expired.
    always_comb
    begin
        tmr_next = tmr_reg;
        if (!run)
        begin
            tmr_next = '0;
        end
        else if (tmr_reg.count == LAST)
        begin
            tmr_next.expired = 1'b1;
        end
        else
        begin
            tmr_next.count = tmr_reg.count + 1'b1;
        end
    end

    // Register the timer state.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tmr_reg <= '0;
        end
        else
        begin
            tmr_reg <= tmr_next;
        end
    end

    assign expired = tmr_reg.expired;

endmodule

/* thcm_monitor.sv */
// Two-hand control monitor with its Wishbone register file.
// Assumes button contacts and the external enable arrive asynchronously on
// pins, and that software configures the block over classic Wishbone.
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module thcm_monitor #(
    parameter int unsigned WINDOW_CYCLES = thcm_pkg::SYNC_WINDOW_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave.
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Button station contacts and external enable.
    input wire logic button1_make_in,
    input wire logic button1_break_in,
    input wire logic button2_make_in,
    input wire logic button2_break_in,
    input wire logic block_enable_in,
    // Monitor results.
    output logic safety_enable_out,
    output logic error_out,
    output logic [31:0] diag_code_out
);

    import thcm_pkg::*;

    // ----------------------------------------------------------------
    // State record
    // ----------------------------------------------------------------

    // All state of the block except the synchroniser and window timer, registered as one word.
    typedef struct packed {
        thcm_state_t state;     // Monitor state.
        logic [31:0] diag;      // Diagnostic code shown to the outside.
        logic qs;               // Safety enable.
        logic err;              // Error present.
        logic cfg_dual;         // Software setting: dual channel.
        logic cfg_ext;          // Software setting: external enable needed.
        logic mode_dual;        // Mode the monitor is running in.
        logic [1:0] settle;     // Settling count after reset.
        logic ack;              // Bus acknowledge.
        logic [31:0] rdata;     // Bus read data.
    } thcm_regs_t;

    // Reset value of the whole record.
    localparam thcm_regs_t RESET_VAL = '{
        state: ST_OFF,
        diag: DG_NO_ENABLE,
        qs: 1'b0,
        err: 1'b0,
        cfg_dual: CTRL_DUAL_RESET,
        cfg_ext: CTRL_EXT_EN_RESET,
        mode_dual: CTRL_DUAL_RESET,
        settle: 2'h0,
        ack: 1'b0,
        rdata: 32'h0000_0000
    };

    thcm_regs_t st_reg;
    thcm_regs_t st_next;

    // ----------------------------------------------------------------
    // Pin synchronisation and window timer
    // ----------------------------------------------------------------

    // Synchronised pins: bit 0..3 the contacts, bit 4 the external enable.
    logic [4:0] pins_sync;
    // Window timer expiry.
    logic window_expired;
    // Timer runs only while an actuation is in progress.
    logic window_run;

    // Every pin passes two flip-flops before any decision reads it.
    thcm_sync #(
        .WIDTH(5)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_in({block_enable_in, button2_break_in, button2_make_in,
                 button1_break_in, button1_make_in}),
        .pin_sync(pins_sync)
    );

    assign window_run = (st_reg.state == ST_ACTUATING);

    // Measures the time from the first input change of an actuation.
    thcm_window_timer #(
        .LIMIT(WINDOW_CYCLES)
    ) u_window (
        .clk(clk),
        .rst(rst),
        .run(window_run),
        .expired(window_expired)
    );

    // ----------------------------------------------------------------
    // Contact patterns
    // ----------------------------------------------------------------

    logic in1;          // Button one make.
    logic in2;          // Button one break, or second make in single mode.
    logic in3;          // Button two make.
    logic in4;          // Button two break.
    logic en_pin;       // External enable level.
    logic at_rest;      // All contacts in rest position.
    logic actuated;     // All contacts in actuated position.
    logic active;       // Block allowed to run.
    logic [31:0] partial_code;  // Code shown during a partial actuation.

    assign in1 = pins_sync[0];
    assign in2 = pins_sync[1];
    assign in3 = pins_sync[2];
    assign in4 = pins_sync[3];
    assign en_pin = pins_sync[4];

    // Rest and actuated patterns depend on the running mode. In dual mode
    // the breaks sit on inputs two and four by the station wiring.
    always_comb
    begin
        if (st_reg.mode_dual)
        begin
            at_rest = !in1 && in2 && !in3 && in4;
            actuated = in1 && !in2 && in3 && !in4;
        end
        else
        begin
            at_rest = !in1 && !in2;
            actuated = in1 && in2;
        end
    end

    // Without an external enable setting the block always runs.
    assign active = !st_reg.cfg_ext || en_pin;

    // A make and break of the same button at one level is undefined.
    always_comb
    begin
        if (!st_reg.mode_dual)
        begin
            partial_code = DG_ONE_CHANNEL;
        end
        else if (in1 == in2)
        begin
            partial_code = DG_BTN1_UNDEF;
        end
        else if (in3 == in4)
        begin
            partial_code = DG_BTN2_UNDEF;
        end
        else
        begin
            partial_code = DG_ONE_CHANNEL;
        end
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------

    // Monitor sequence and Wishbone slave in one combinational pass.
    always_comb
    begin
        st_next = st_reg;

        // Settling count saturates; the pins are trusted once it is full.
        if (st_reg.settle != SETTLE_LAST)
        begin
            st_next.settle = st_reg.settle + 2'h1;
        end

        // Deactivation or a change of mode restarts the monitor, so the
        // startup check runs again under the new setting.
        if (!active || (st_reg.cfg_dual != st_reg.mode_dual))
        begin
            st_next.state = ST_OFF;
            st_next.mode_dual = st_reg.cfg_dual;
            st_next.qs = 1'b0;
            st_next.err = 1'b0;
            st_next.diag = DG_NO_ENABLE;
        end
        else
        begin
            unique case (st_reg.state)
                ST_OFF:
                begin
                    st_next.diag = DG_NO_ENABLE;
                    if (st_reg.settle == SETTLE_LAST)
                    begin
                        st_next.state = ST_START;
                        st_next.diag = DG_WAIT_FIRST;
                    end
                end
                ST_START:
                begin
                    // Any contact already operated at startup is a fault.
                    if (!at_rest)
                    begin
                        st_next.state = ST_ERROR;
                        st_next.err = 1'b1;
                        st_next.diag = DG_ERR_STARTUP;
                    end
                    else
                    begin
                        st_next.state = ST_REST;
                        st_next.diag = DG_REST;
                    end
                end
                ST_REST:
                begin
                    // The first contact change opens the window.
                    if (!at_rest)
                    begin
                        st_next.state = ST_ACTUATING;
                        st_next.diag = partial_code;
                    end
                    else
                    begin
                        st_next.diag = DG_REST;
                    end
                end
                ST_ACTUATING:
                begin
                    // Expiry wins over a completion in the same cycle:
                    // the second hand was then already too late.
                    if (window_expired)
                    begin
                        st_next.state = ST_ERROR;
                        st_next.err = 1'b1;
                        st_next.diag = DG_ERR_LATE;
                    end
                    else if (actuated)
                    begin
                        st_next.state = ST_ENABLED;
                        st_next.qs = 1'b1;
                        st_next.diag = DG_OPERATED;
                    end
                    else if (at_rest)
                    begin
                        // Opened and closed again with no partner.
                        st_next.state = ST_ERROR;
                        st_next.err = 1'b1;
                        st_next.diag = DG_ERR_ONE_CH;
                    end
                    else
                    begin
                        st_next.diag = partial_code;
                    end
                end
                ST_ENABLED:
                begin
                    // Any contact leaving its actuated level ends the
                    // enable on the next edge.
                    if (!actuated)
                    begin
                        st_next.state = ST_RELEASE;
                        st_next.qs = 1'b0;
                        st_next.diag = DG_WAIT_FIRST;
                    end
                end
                ST_RELEASE:
                begin
                    // A new enable needs a full return to rest first.
                    if (at_rest)
                    begin
                        st_next.state = ST_REST;
                        st_next.diag = DG_REST;
                    end
                end
                ST_ERROR:
                begin
                    // The rest pattern is the acknowledgement.
                    if (at_rest)
                    begin
                        st_next.state = ST_REST;
                        st_next.err = 1'b0;
                        st_next.diag = DG_REST;
                    end
                end
            endcase
        end

        // Wishbone: acknowledge one cycle after the request is seen and
        // drop the acknowledge in the following cycle.
        st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
        st_next.rdata = 32'h0000_0000;
        if (wb_cyc_i && wb_stb_i && !st_reg.ack && !wb_we_i)
        begin
            // Read data is captured with the acknowledge; unmapped
            // addresses read as zero.
            case (wb_adr_i)
                CTRL_OFS:
                begin
                    st_next.rdata[CTRL_DUAL_BIT] = st_reg.cfg_dual;
                    st_next.rdata[CTRL_EXT_EN_BIT] = st_reg.cfg_ext;
                end
                STATUS_OFS:
                begin
                    st_next.rdata[STATUS_ENABLE_BIT] = st_reg.qs;
                    st_next.rdata[STATUS_ERROR_BIT] = st_reg.err;
                    st_next.rdata[STATUS_PINS_LSB +: 5] = pins_sync;
                end
                DIAG_OFS:
                begin
                    st_next.rdata = st_reg.diag;
                end
                default:
                begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Writes take effect on the edge that ends the acknowledge;
        // only byte lane zero holds writable bits.
        if (wb_cyc_i && wb_stb_i && st_reg.ack && wb_we_i && wb_sel_i[0]
            && (wb_adr_i == CTRL_OFS))
        begin
            st_next.cfg_dual = wb_dat_i[CTRL_DUAL_BIT];
            st_next.cfg_ext = wb_dat_i[CTRL_EXT_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // One register for the whole record; synchronous reset.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= RESET_VAL;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the record
    // ----------------------------------------------------------------

    assign safety_enable_out = st_reg.qs;
    assign error_out = st_reg.err;
    assign diag_code_out = st_reg.diag;
    assign wb_ack_o = st_reg.ack;
    assign wb_dat_o = st_reg.rdata;

endmodule

/* thcm_station.sv */
// Behavioural model of the two-hand pushbutton station contacts.
// Assumes the bench commands presses as levels; a contact reads 1 when closed.
`timescale 1ns/10ps
module thcm_station (
    // Operator commands.
    input wire logic b1_press,
    input wire logic b2_press,
    input wire logic b1_half,
    input wire logic b2_half,
    input wire logic dual,
    // Contacts towards the monitor.
    output logic button1_make_in,
    output logic button1_break_in,
    output logic button2_make_in,
    output logic button2_break_in
);
    // A half press closes the make while the break still hangs closed.
    // In single channel the second make sits on input two; inputs three and four idle low.
    assign button1_make_in = b1_press;
    assign button1_break_in = dual ? (!b1_press || b1_half) : b2_press;
    assign button2_make_in = dual ? b2_press : 1'b0;
    assign button2_break_in = dual ? (!b2_press || b2_half) : 1'b0;
endmodule

/* thcm_props.sv */
// Checker for the two-hand control monitor, bound to its top module.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/10ps
module thcm_props
    import thcm_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Wishbone slave.
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Station contacts and external enable.
    input wire logic button1_make_in,
    input wire logic button1_break_in,
    input wire logic button2_make_in,
    input wire logic button2_break_in,
    input wire logic block_enable_in,
    // Monitor results.
    input wire logic safety_enable_out,
    input wire logic error_out,
    input wire logic [31:0] diag_code_out
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    // All checks share one clock, so reset masks them all at once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_enable_code: assert property (safety_enable_out |-> diag_code_out == DG_OPERATED)
        else $error("enable without operated code");
    a_error_code: assert property (error_out == (diag_code_out[15:12] == 4'hF))
        else $error("error flag and code disagree");
    a_error_no_enable: assert property (error_out |-> !safety_enable_out)
        else $error("enable during error");
    // Pin path takes about three edges, so four covers it with margin.
    a_drop_on_release: assert property (safety_enable_out && $fell(button1_make_in)
        |-> ##[1:4] !safety_enable_out)
        else $error("enable held after release");
    a_reset_quiet: assert property ($fell(rst) |-> diag_code_out == DG_NO_ENABLE
        && !safety_enable_out && !error_out)
        else $error("outputs active after reset");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
endmodule
bind thcm_monitor thcm_props thcm_props_inst (.clk, .rst, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .button1_make_in, .button1_break_in,
    .button2_make_in, .button2_break_in, .block_enable_in, .safety_enable_out, .error_out,
    .diag_code_out);

/* tb_two_hand_control_monitor.sv */
// Self-checking bench for the two-hand control monitor.
// Assumes the station model and a short window of 50 cycles.
`timescale 1ns/10ps
module tb_two_hand_control_monitor;
    import thcm_pkg::*;
    logic clk = 0, rst = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, block_enable_in = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, diag_code_out, rd;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_ack_o, safety_enable_out, error_out, b1mk, b1brk, b2mk, b2brk;
    logic p1 = 0, p2 = 0, h1 = 0, h2 = 0, dual = 1;
    int fail_count = 0, checks_done = 0;
    // 40 MHz clock.
    always #12.5 clk = ~clk;
    thcm_monitor #(.WINDOW_CYCLES(50)) thcm_monitor_inst (.clk, .rst, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
        .button1_make_in(b1mk), .button1_break_in(b1brk), .button2_make_in(b2mk),
        .button2_break_in(b2brk), .block_enable_in, .safety_enable_out, .error_out,
        .diag_code_out);
    thcm_station thcm_station_inst (.b1_press(p1), .b2_press(p2), .b1_half(h1), .b2_half(h2),
        .dual, .button1_make_in(b1mk), .button1_break_in(b1brk), .button2_make_in(b2mk),
        .button2_break_in(b2brk));
    // Prints the counts and the verdict, then stops the run.
    task end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // Classic single cycle; the request stands until ack is sampled.
    task wb(input logic [7:0] adr, input logic we, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= wd;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 20)
        begin
            fail_count++;
            end_of_test();
        end
    endtask
    // Waits a bounded time for a code, then compares all three outputs.
    task expect_state(input logic [31:0] code, input logic en, input logic er);
        int n;
        n = 0;
        while (diag_code_out !== code && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 200)
        begin
            fail_count++;
            end_of_test();
        end
        check(diag_code_out, code);
        check({31'h0, safety_enable_out}, {31'h0, en});
        check({31'h0, error_out}, {31'h0, er});
    endtask
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb(CTRL_OFS, 1'b0, 32'h0);
        check(rd, 32'h0000_0001);
        wb(8'h0C, 1'b0, 32'h0);
        check(rd, 32'h0000_0000);
        expect_state(DG_REST, 1'b0, 1'b0);
        // Dual channel: press one button, then the other inside the window.
        p1 <= 1'b1;
        expect_state(DG_ONE_CHANNEL, 1'b0, 1'b0);
        p2 <= 1'b1;
        expect_state(DG_OPERATED, 1'b1, 1'b0);
        wb(STATUS_OFS, 1'b0, 32'h0);
        check(rd[1:0], 32'h1);
        check(rd[8:4], 32'h5);
        p1 <= 1'b0;
        expect_state(DG_WAIT_FIRST, 1'b0, 1'b0);
        p2 <= 1'b0;
        expect_state(DG_REST, 1'b0, 1'b0);
        // Late second hand gives an error that a late press cannot clear.
        p1 <= 1'b1;
        expect_state(DG_ERR_LATE, 1'b0, 1'b1);
        p2 <= 1'b1;
        repeat (10) @(posedge clk);
        expect_state(DG_ERR_LATE, 1'b0, 1'b1);
        p1 <= 1'b0;
        p2 <= 1'b0;
        expect_state(DG_REST, 1'b0, 1'b0);
        h1 <= 1'b1;
        p1 <= 1'b1;
        expect_state(DG_BTN1_UNDEF, 1'b0, 1'b0);
        p1 <= 1'b0;
        h1 <= 1'b0;
        h2 <= 1'b1;
        p2 <= 1'b1;
        expect_state(DG_BTN2_UNDEF, 1'b0, 1'b0);
        p2 <= 1'b0;
        expect_state(DG_ERR_ONE_CH, 1'b0, 1'b1);
        // Restart with one button already held.
        h2 <= 1'b0;
        p1 <= 1'b1;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        expect_state(DG_ERR_STARTUP, 1'b0, 1'b1);
        p1 <= 1'b0;
        expect_state(DG_REST, 1'b0, 1'b0);
        // Single channel: two makes on inputs one and two.
        dual <= 1'b0;
        wb(CTRL_OFS, 1'b1, 32'h0000_0000);
        // The mode change restarts the monitor before the startup check.
        expect_state(DG_NO_ENABLE, 1'b0, 1'b0);
        expect_state(DG_REST, 1'b0, 1'b0);
        p2 <= 1'b1;
        expect_state(DG_ONE_CHANNEL, 1'b0, 1'b0);
        p1 <= 1'b1;
        expect_state(DG_OPERATED, 1'b1, 1'b0);
        p1 <= 1'b0;
        p2 <= 1'b0;
        expect_state(DG_REST, 1'b0, 1'b0);
        // External enable gates the monitor sequence.
        wb(CTRL_OFS, 1'b1, 32'h0000_0002);
        expect_state(DG_NO_ENABLE, 1'b0, 1'b0);
        block_enable_in <= 1'b1;
        expect_state(DG_REST, 1'b0, 1'b0);
        wb(DIAG_OFS, 1'b0, 32'h0);
        check(rd, DG_REST);
        // A write without byte lane zero leaves the settings alone.
        wb_sel_i <= 4'hE;
        wb(CTRL_OFS, 1'b1, 32'h0000_0001);
        wb_sel_i <= 4'hF;
        wb(CTRL_OFS, 1'b0, 32'h0);
        check(rd, 32'h0000_0002);
        end_of_test();
    end
endmodule
